// >>> rtl/can_transceiver_mode_control.sv
// Functional notes
// - select low enters normal mode only while supply is good
// - select high enters stand-by only while supply is good
// - txd low at normal entry drives dominant
// - time-out runs only in normal mode
// - receive output held high during transitions
// - stand-by hands receive output to wake receiver
// - dominant at stand-by entry keeps output high
// - first bus change arms wake-up indication
// - recessive entry: long dominant pulse signalled low
// - stand-by: transmitter, normal receiver off
// - stand-by output follows only filtered levels
// - transmitter stays off until transition ends
// - normal mode: receive output mirrors bus
// - select high blanks receive, stops transmitter
// - mode changes start only while supply is good
// - dominant entry waits for filtered recessive
// - transition finishes within twenty microseconds
// - filter time between half and five microseconds
`timescale 1ns/1ns

// ============================================================
// wake-up event queue
module rx_event_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
)
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // draining side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    wire              push;
    wire              pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = count_reg != CW'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end

endmodule // rx_event_fifo

// ============================================================
// mode control and receive gating
module can_transceiver_mode_control
    import can_mode_pkg::*;
#(
    parameter int TXD_TIMEOUT_NS = TXD_TIMEOUT_DEF_NS
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // controller pins
    input  wire logic mode_select_input,
    input  wire logic txd_in,
    output logic      rxd_out,
    // supply monitor and bus comparator
    input  wire logic supply_ok,
    input  wire logic bus_dominant,
    // driver and receiver control
    output logic      tx_enable,
    output logic      tx_dominant,
    output logic      normal_rx_enable,
    output logic      lowpower_rx_enable,
    // status
    output logic      mode_normal,
    output logic      txd_timeout
);
    localparam logic [TO_W-1:0] TIMEOUT_TICKS = TO_W'(TXD_TIMEOUT_NS / TICK_NS);
    localparam logic [12:0]     MODE_MAX_CYC  = 13'(MODE_MAX_NS * CLK_FREQ_MHZ / 1000);

    logic [1:0]        stb_sync_reg;
    logic [1:0]        txd_sync_reg;
    logic [1:0]        sup_sync_reg;
    logic [1:0]        bus_sync_reg;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick_reg;
    mode_state_type    state_reg;
    mode_state_type    state_next;
    logic [MODE_W-1:0] mode_cnt_reg;
    logic              filt_level_reg;
    logic [FILT_W-1:0] filt_cnt_reg;
    logic [TO_W-1:0]   to_cnt_reg;
    logic              rxd_reg;
    logic              tx_en_reg;
    logic              tx_dom_reg;
    logic              nrx_en_reg;
    logic              lprx_en_reg;
    logic              normal_reg;
    logic              timeout_reg;
    logic              q_in_ready;
    logic              q_out_valid;
    logic [RXQ_WIDTH-1:0] q_out_data;

    wire stb_s      = stb_sync_reg[1];
    wire txd_s      = txd_sync_reg[1];
    wire sup_s      = sup_sync_reg[1];
    wire bus_s      = bus_sync_reg[1];
    wire in_transit = (state_reg == ST_TO_NORMAL) || (state_reg == ST_TO_STANDBY);
    wire mode_done  = tick_reg && (mode_cnt_reg == MODE_LAST);
    wire standby    = state_reg == ST_STANDBY;
    wire entering   = (state_next == ST_STANDBY) && !standby;
    wire filt_full  = filt_cnt_reg == FILTER_TICKS;
    wire q_in_valid = standby && (bus_s != filt_level_reg) && filt_full;
    wire q_push     = q_in_valid && q_in_ready;
    wire q_pop      = q_out_valid && standby;
    wire normal_nx  = state_next == ST_NORMAL;
    wire to_full    = to_cnt_reg == TIMEOUT_TICKS;
    wire timeout_nx = normal_nx && !txd_s && to_full;
    wire rxd_next   = normal_nx ? !bus_s
                    : (state_next != ST_STANDBY || !standby) ? 1'b1
                    : q_pop ? !q_out_data[0] : rxd_reg;

    // ============================================================
    // pin synchronisers and timebase
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stb_sync_reg <= 2'h3;
            txd_sync_reg <= 2'h3;
            sup_sync_reg <= 2'h0;
            bus_sync_reg <= 2'h0;
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end
        else
        begin
            stb_sync_reg <= {stb_sync_reg[0], mode_select_input};
            txd_sync_reg <= {txd_sync_reg[0], txd_in};
            sup_sync_reg <= {sup_sync_reg[0], supply_ok};
            bus_sync_reg <= {bus_sync_reg[0], bus_dominant};
            tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + TICK_W'(1);
            tick_reg     <= tick_cnt_reg == TICK_LAST;
        end
    end

    // ============================================================
    // mode sequencing
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STANDBY:
                if (sup_s && !stb_s)
                    state_next = ST_TO_NORMAL;
            ST_TO_NORMAL:
                if (sup_s && stb_s)
                    state_next = ST_TO_STANDBY;
                else if (mode_done)
                    state_next = ST_NORMAL;
            ST_NORMAL:
                if (sup_s && stb_s)
                    state_next = ST_TO_STANDBY;
            ST_TO_STANDBY:
                if (sup_s && !stb_s)
                    state_next = ST_TO_NORMAL;
                else if (mode_done)
                    state_next = ST_STANDBY;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state_reg <= ST_TO_STANDBY;
        else
            state_reg <= state_next;
    end

    // blanking timer restarts on every state change
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || state_next != state_reg || !in_transit)
            mode_cnt_reg <= '0;
        else if (tick_reg)
            mode_cnt_reg <= mode_cnt_reg + MODE_W'(1);
    end

    // ============================================================
    // low-power receiver activity filter
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            filt_level_reg <= 1'b0;
            filt_cnt_reg   <= '0;
        end
        else if (entering)
        begin
            filt_level_reg <= bus_s;
            filt_cnt_reg   <= '0;
        end
        else if (!standby || bus_s == filt_level_reg || q_push)
        begin
            filt_level_reg <= q_push ? bus_s : filt_level_reg;
            filt_cnt_reg   <= '0;
        end
        else if (tick_reg && !filt_full)
            filt_cnt_reg <= filt_cnt_reg + FILT_W'(1);
    end

    rx_event_fifo #(
        .WIDTH (RXQ_WIDTH),
        .DEPTH (RXQ_DEPTH)
    ) u_rx_queue (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .flush     (!standby),
        .in_valid  (q_in_valid),
        .in_data   (bus_s),
        .in_ready  (q_in_ready),
        .out_valid (q_out_valid),
        .out_data  (q_out_data),
        .out_ready (standby)
    );

    // ============================================================
    // transmit time-out, only counts in normal mode
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !normal_nx || txd_s)
            to_cnt_reg <= '0;
        else if (tick_reg && !to_full)
            to_cnt_reg <= to_cnt_reg + TO_W'(1);
    end

    // ============================================================
    // registered outputs
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rxd_reg     <= 1'b1;
            tx_en_reg   <= 1'b0;
            tx_dom_reg  <= 1'b0;
            nrx_en_reg  <= 1'b0;
            lprx_en_reg <= 1'b1;
            normal_reg  <= 1'b0;
            timeout_reg <= 1'b0;
        end
        else
        begin
            rxd_reg     <= rxd_next;
            tx_en_reg   <= normal_nx;
            tx_dom_reg  <= normal_nx && !txd_s && !timeout_nx;
            nrx_en_reg  <= normal_nx;
            lprx_en_reg <= state_next == ST_STANDBY;
            normal_reg  <= normal_nx;
            timeout_reg <= timeout_nx;
        end
    end

    assign rxd_out            = rxd_reg;
    assign tx_enable          = tx_en_reg;
    assign tx_dominant        = tx_dom_reg;
    assign normal_rx_enable   = nrx_en_reg;
    assign lowpower_rx_enable = lprx_en_reg;
    assign mode_normal        = normal_reg;
    assign txd_timeout        = timeout_reg;

    // ============================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_leave_standby;
        standby && sup_s && !stb_s;
    endsequence

    sequence s_enter_normal_low;
        state_reg == ST_TO_NORMAL && mode_done && !stb_s && !txd_s;
    endsequence

    property p_go_normal;
        s_leave_standby |=> state_reg == ST_TO_NORMAL && rxd_out && !lowpower_rx_enable;
    endproperty
    a_go_normal: assert property (p_go_normal) else $error("normal entry failed");

    property p_go_standby;
        state_reg == ST_NORMAL && sup_s && stb_s |=> state_reg == ST_TO_STANDBY && rxd_out;
    endproperty
    a_go_standby: assert property (p_go_standby) else $error("standby entry failed");

    property p_dominant_entry;
        s_enter_normal_low |=> tx_dominant && tx_enable && mode_normal;
    endproperty
    a_dominant_entry: assert property (p_dominant_entry) else $error("no dominant");

    property p_timeout;
        txd_timeout |-> mode_normal && !tx_dominant;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out misbehaves");

    property p_blank;
        in_transit |-> rxd_out && !tx_enable && !tx_dominant && !normal_rx_enable;
    endproperty
    a_blank: assert property (p_blank) else $error("transition not blanked");

    property p_standby_quiet;
        standby |-> !tx_enable && !tx_dominant && lowpower_rx_enable && !normal_rx_enable;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("standby drives");

    property p_filter;
        q_push |-> filt_cnt_reg == FILTER_TICKS && $stable(bus_s);
    endproperty
    a_filter: assert property (p_filter) else $error("unfiltered event");

    property p_normal_rx;
        state_reg == ST_NORMAL |-> rxd_out == !$past(bus_s);
    endproperty
    a_normal_rx: assert property (p_normal_rx) else $error("rxd not mirroring bus");

    property p_supply_hold;
        !sup_s && (standby || state_reg == ST_NORMAL) |=> $stable(state_reg);
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("mode changed unsupplied");

    // cycles spent in the current transition, apart from the tick timer
    logic [12:0] transit_cyc_reg;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !in_transit || state_next != state_reg)
            transit_cyc_reg <= '0;
        else
            transit_cyc_reg <= transit_cyc_reg + 13'h1;
    end

    property p_mode_bound;
        in_transit |-> transit_cyc_reg < MODE_MAX_CYC;
    endproperty
    a_mode_bound: assert property (p_mode_bound) else $error("transition too long");

endmodule // can_transceiver_mode_control

// >>> rtl/can_mode_pkg.sv
package can_mode_pkg;

    // ============================================================
    // timebase
    localparam int CLK_FREQ_MHZ = 250;
    localparam int TICK_NS      = 100;
    localparam int TICK_CYCLES  = TICK_NS * CLK_FREQ_MHZ / 1000;
    localparam int TICK_W       = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // ============================================================
    // bus activity filter, least time rounds up
    localparam int FILTER_MIN_NS  = 500;
    localparam int FILTER_MAX_NS  = 5000;
    localparam int FILTER_TIME_NS = 1000;
    localparam int FILT_W         = 4;
    localparam logic [FILT_W-1:0] FILTER_TICKS =
        FILT_W'((FILTER_TIME_NS + TICK_NS - 1) / TICK_NS);

    // ============================================================
    // mode transition blanking, longest time rounds down
    localparam int MODE_MAX_NS  = 20000;
    localparam int MODE_TIME_NS = 10000;
    localparam int MODE_W       = 7;
    localparam logic [MODE_W-1:0] MODE_LAST = MODE_W'(MODE_TIME_NS / TICK_NS - 1);

    // ============================================================
    // wake-up reaction bound and transmit time-out
    localparam int WAKEUP_REACTION_TIME_NS = 5000;
    localparam int TXD_TIMEOUT_DEF_NS      = 1000000;
    localparam int TO_W                    = 24;

    // ============================================================
    // wake-up event queue
    localparam int RXQ_WIDTH = 1;
    localparam int RXQ_DEPTH = 8;

    typedef enum logic [1:0] {
        ST_STANDBY    = 2'h0,
        ST_TO_NORMAL  = 2'h1,
        ST_NORMAL     = 2'h2,
        ST_TO_STANDBY = 2'h3
    } mode_state_type;

endpackage

// >>> tb/can_ctrl_model.sv
`timescale 1ns/1ns

// ============================================================
// controller side: mode pin and transmit data
module can_ctrl_model
(
    // clock
    input  wire logic clk_sys,
    // commands from the bench
    input  wire logic want_standby,
    input  wire logic want_dominant,
    // pins
    output logic      mode_select_input,
    output logic      txd_in
);
    initial
    begin
        mode_select_input = 1'b1;
        txd_in            = 1'b1;
    end

    always @(negedge clk_sys)
    begin
        mode_select_input <= want_standby;
        // txd stays high unless a dominant level is wanted on purpose
        txd_in            <= !want_dominant;
    end
endmodule // can_ctrl_model

// >>> tb/tb.sv
`timescale 1ns/1ns

// ============================================================
// bench top
module tb;
    logic clk_sys       = 1'b0;
    logic rst_n         = 1'b0;
    logic supply_ok     = 1'b1;
    logic bus_dominant  = 1'b0;
    logic want_standby  = 1'b1;
    logic want_dominant = 1'b0;
    logic mode_select_input, txd_in, rxd_out, tx_enable, tx_dominant;
    logic normal_rx_enable, lowpower_rx_enable, mode_normal, txd_timeout;
    int   err_total     = 0;
    int   n_compared    = 0;

    always #2 clk_sys = ~clk_sys;

    can_ctrl_model ctrl_u (.clk_sys(clk_sys), .want_standby(want_standby),
        .want_dominant(want_dominant), .mode_select_input(mode_select_input),
        .txd_in(txd_in));

    can_transceiver_mode_control #(.TXD_TIMEOUT_NS(2000)) dut_u (.clk_sys(clk_sys),
        .rst_n(rst_n), .mode_select_input(mode_select_input), .txd_in(txd_in),
        .rxd_out(rxd_out), .supply_ok(supply_ok), .bus_dominant(bus_dominant),
        .tx_enable(tx_enable), .tx_dominant(tx_dominant),
        .normal_rx_enable(normal_rx_enable), .lowpower_rx_enable(lowpower_rx_enable),
        .mode_normal(mode_normal), .txd_timeout(txd_timeout));

    task automatic check(input logic seen, input logic exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wait_rxd(input logic val, input int limit, input string what);
        int n;
        n = 0;
        while (rxd_out !== val && n < limit)
        begin
            cycles(1);
            n++;
        end
        check(rxd_out, val, what);
    endtask

    // request a mode and watch the blanked transition
    task automatic go_mode(input logic normal);
        int n;
        n = 4;
        want_standby = !normal;
        cycles(4);
        while ((normal ? mode_normal : lowpower_rx_enable) !== 1'b1 && n < 5000)
        begin
            check(rxd_out, 1'b1, "rxd not blanked");
            check(tx_enable | tx_dominant, 1'b0, "driver on");
            cycles(1);
            n++;
        end
        check(n < 5000, 1'b1, "transition too long");
    endtask

    task automatic t_reset;
        check(rxd_out, 1'b1, "reset rxd");
        check(tx_enable, 1'b0, "reset tx");
        check(mode_normal, 1'b0, "reset mode");
        check(txd_timeout, 1'b0, "reset timeout");
        rst_n = 1'b1;
        go_mode(1'b0);
        check(lowpower_rx_enable, 1'b1, "lp rx off");
        check(normal_rx_enable, 1'b0, "rx on");
        $display("test reset done");
    endtask

    task automatic t_filter;
        bus_dominant = 1'b1;
        for (int i = 0; i < 400; i++)
        begin
            if (i == 100)
                bus_dominant = 1'b0;
            cycles(1);
            check(rxd_out, 1'b1, "short pulse seen");
        end
        bus_dominant = 1'b1;
        wait_rxd(1'b0, 1500, "wake pulse lost");
        bus_dominant = 1'b0;
        wait_rxd(1'b1, 1500, "recessive lost");
        $display("test filter done");
    endtask

    task automatic t_normal;
        bus_dominant = 1'b1;
        go_mode(1'b1);
        check(mode_normal, 1'b1, "no normal");
        check(normal_rx_enable & !lowpower_rx_enable, 1'b1, "rx select");
        for (int i = 0; i < 4; i++)
        begin
            bus_dominant = i[0];
            cycles(4);
            check(rxd_out, !i[0], "rxd vs bus");
        end
        want_dominant = 1'b1;
        cycles(5);
        check(tx_dominant, 1'b1, "no transmit");
        go_mode(1'b0);
        want_dominant = 1'b0;
        check(tx_enable | normal_rx_enable, 1'b0, "standby driver");
        check(lowpower_rx_enable, 1'b1, "lp rx off");
        $display("test normal done");
    endtask

    task automatic t_dom_entry;
        for (int i = 0; i < 1000; i++)
        begin
            bus_dominant = (i < 400 || i >= 500);
            cycles(1);
            check(rxd_out, 1'b1, "dominant woke");
        end
        bus_dominant = 1'b0;
        cycles(500);
        check(rxd_out, 1'b1, "recessive shown");
        bus_dominant = 1'b1;
        wait_rxd(1'b0, 1500, "armed pulse lost");
        $display("test dominant entry done");
    endtask

    task automatic t_supply;
        bus_dominant = 1'b0;
        wait_rxd(1'b1, 1500, "recessive lost");
        supply_ok = 1'b0;
        want_dominant = 1'b1;
        want_standby = 1'b0;
        cycles(5500);
        check(mode_normal, 1'b0, "unsupplied change");
        check(txd_timeout, 1'b0, "standby timeout");
        supply_ok = 1'b1;
        bus_dominant = 1'b1;
        go_mode(1'b1);
        check(tx_dominant, 1'b1, "no entry dominant");
        for (int i = 0; i < 700 && txd_timeout !== 1'b1; i++)
            cycles(1);
        check(txd_timeout, 1'b1, "no timeout");
        check(tx_dominant, 1'b0, "driven past timeout");
        want_dominant = 1'b0;
        cycles(8);
        check(txd_timeout, 1'b0, "timeout stuck");
        $display("test supply done");
    endtask

    // filtered levels leave the event queue in order; a reversal aborts the transition
    task automatic t_queue;
        go_mode(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            bus_dominant = i[0];
            cycles(400);
            check(rxd_out, !i[0], "queued level lost");
        end
        want_standby = 1'b0;
        cycles(600);
        check(lowpower_rx_enable | mode_normal, 1'b0, "not in transition");
        check(rxd_out, 1'b1, "rxd not blanked mid transition");
        go_mode(1'b0);
        check(mode_normal, 1'b0, "reversal reached normal");
        check(lowpower_rx_enable, 1'b1, "lp rx off after reversal");
        check(tx_enable | tx_dominant, 1'b0, "driver on after reversal");
        $display("test queue done");
    endtask

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        cycles(12);
        t_reset;
        t_filter;
        t_normal;
        t_dom_entry;
        t_supply;
        t_queue;
        results;
    end

    // watchdog
    initial
    begin
        #400000;
        err_total++;
        results;
    end
endmodule // tb
